// File: core/hts_capture_reg.sv
// One read-only capture field: loaded on an event, zeroed by a clear
`timescale 1ns/1ps
module hts_capture_reg #(
    parameter int WIDTH = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic load,
    input wire logic clear,
    // Data
    input wire logic [WIDTH-1:0] value,
    output logic [WIDTH-1:0] field_q
);
    import hts_pkg::*;

    logic [WIDTH-1:0] field_d;

    // ------------------------------------------------------------
    // Next value: a capture wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_comb
    begin
        field_d = field_q;
        if (load)
        begin
            field_d = value;
        end
        else if (clear)
        begin
            field_d = HTS_RESET_VAL[WIDTH-1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            field_q <= '0;
        end
        else
        begin
            field_q <= field_d;
        end
    end

endmodule

// File: core/hts_pkg.sv
// Constants and types shared by the over-temperature time-stamp capture block
package hts_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int HTS_ADDR_W = 8;
    localparam int HTS_DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [HTS_ADDR_W-1:0] HTS_OFS_HOURS = 8'h22;
    localparam logic [HTS_ADDR_W-1:0] HTS_OFS_DATE = 8'h23;
    localparam logic [HTS_ADDR_W-1:0] HTS_OFS_MONTH = 8'h24;

    // ------------------------------------------------------------
    // Field widths (stored BCD bits, from bit 0 upward)
    // ------------------------------------------------------------
    localparam int HTS_HOURS_W = 6;
    localparam int HTS_DATE_W = 6;
    localparam int HTS_MONTH_W = 5;

    // ------------------------------------------------------------
    // Reset and clear values, read value of unmapped addresses
    // ------------------------------------------------------------
    localparam logic [HTS_DATA_W-1:0] HTS_RESET_VAL = 8'h00;
    localparam logic [HTS_DATA_W-1:0] HTS_UNMAPPED_VAL = 8'h00;

    // ------------------------------------------------------------
    // Overwrite selection encoding
    // ------------------------------------------------------------
    localparam logic HTS_KEEP_FIRST = 1'h0;
    localparam logic HTS_KEEP_LAST = 1'h1;

    // ------------------------------------------------------------
    // Stamp holding state
    // ------------------------------------------------------------
    typedef enum logic {
        HTS_EMPTY,
        HTS_HELD
    } hts_stamp_t;

endpackage

// File: core/hts_stamp.sv
// Over-temperature event time stamp: hours, date and month capture registers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module hts_stamp (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register port
    input wire logic [hts_pkg::HTS_ADDR_W-1:0] reg_addr,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hts_pkg::HTS_DATA_W-1:0] reg_rdata_q,
    // Calendar time base (BCD)
    input wire logic [hts_pkg::HTS_DATA_W-1:0] cal_hours,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] cal_date,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] cal_month,
    // Stamp control from the rest of the unit
    input wire logic hot_event,
    input wire logic hot_stamp_enable,
    input wire logic hot_stamp_overwrite_select,
    input wire logic hot_stamp_clear,
    // Status
    output logic stamp_held_q
);
    import hts_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [HTS_HOURS_W-1:0] hours_q;
    logic [HTS_DATE_W-1:0] date_q;
    logic [HTS_MONTH_W-1:0] month_q;
    logic [HTS_DATA_W-1:0] hot_event_hours;
    logic [HTS_DATA_W-1:0] hot_event_date;
    logic [HTS_DATA_W-1:0] hot_event_month;
    hts_stamp_t stamp_q;
    hts_stamp_t stamp_d;
    logic capture;
    logic [HTS_DATA_W-1:0] reg_rdata_d;

    // ------------------------------------------------------------
    // Capture decision
    // ------------------------------------------------------------
    // Disabled: nothing is recorded. Keep-first: only while empty.
    always_comb
    begin
        capture = 1'b0;
        if (hot_event && hot_stamp_enable)
        begin
            if (hot_stamp_overwrite_select == HTS_KEEP_LAST)
            begin
                capture = 1'b1;
            end
            else
            begin
                capture = (stamp_q == HTS_EMPTY);
            end
        end
    end

    // ------------------------------------------------------------
    // Stamp holding state
    // ------------------------------------------------------------
    // A new capture wins over a clear arriving in the same cycle
    always_comb
    begin
        stamp_d = stamp_q;
        case (stamp_q)
            HTS_EMPTY:
            begin
                if (capture)
                begin
                    stamp_d = HTS_HELD;
                end
            end
            HTS_HELD:
            begin
                if (!capture && hot_stamp_clear)
                begin
                    stamp_d = HTS_EMPTY;
                end
            end
            default:
            begin
                stamp_d = HTS_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stamp_q <= HTS_EMPTY;
            stamp_held_q <= 1'b0;
        end
        else
        begin
            stamp_q <= stamp_d;
            stamp_held_q <= (stamp_d == HTS_HELD);
        end
    end

    // ------------------------------------------------------------
    // Capture fields, all loaded by one common strobe
    // ------------------------------------------------------------
    hts_capture_reg #(
        .WIDTH(HTS_HOURS_W)
    ) u_hours (
        .clock(clock),
        .nrst(nrst),
        .load(capture),
        .clear(hot_stamp_clear),
        .value(cal_hours[HTS_HOURS_W-1:0]),
        .field_q(hours_q)
    );

    hts_capture_reg #(
        .WIDTH(HTS_DATE_W)
    ) u_date (
        .clock(clock),
        .nrst(nrst),
        .load(capture),
        .clear(hot_stamp_clear),
        .value(cal_date[HTS_DATE_W-1:0]),
        .field_q(date_q)
    );

    hts_capture_reg #(
        .WIDTH(HTS_MONTH_W)
    ) u_month (
        .clock(clock),
        .nrst(nrst),
        .load(capture),
        .clear(hot_stamp_clear),
        .value(cal_month[HTS_MONTH_W-1:0]),
        .field_q(month_q)
    );

    // ------------------------------------------------------------
    // Register images, unused upper bits read as zero
    // ------------------------------------------------------------
    assign hot_event_hours = {{(HTS_DATA_W-HTS_HOURS_W){1'b0}}, hours_q};
    assign hot_event_date = {{(HTS_DATA_W-HTS_DATE_W){1'b0}}, date_q};
    assign hot_event_month = {{(HTS_DATA_W-HTS_MONTH_W){1'b0}}, month_q};

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    // Writes are decoded nowhere: every register here is read-only
    always_comb
    begin
        reg_rdata_d = HTS_UNMAPPED_VAL;
        if (reg_rd)
        begin
            case (reg_addr)
                HTS_OFS_HOURS: reg_rdata_d = hot_event_hours;
                HTS_OFS_DATE: reg_rdata_d = hot_event_date;
                HTS_OFS_MONTH: reg_rdata_d = hot_event_month;
                default: reg_rdata_d = HTS_UNMAPPED_VAL;
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            reg_rdata_q <= HTS_RESET_VAL;
        end
        else
        begin
            reg_rdata_q <= reg_rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence s_enabled_event;
        hot_event && hot_stamp_enable;
    endsequence

    sequence s_last_event;
        s_enabled_event ##0 (hot_stamp_overwrite_select == HTS_KEEP_LAST);
    endsequence

    sequence s_first_event_empty;
        s_enabled_event ##0 (hot_stamp_overwrite_select == HTS_KEEP_FIRST)
            ##0 !stamp_held_q;
    endsequence

    sequence s_read_hours;
        reg_rd && (reg_addr == HTS_OFS_HOURS);
    endsequence

    sequence s_read_date;
        reg_rd && (reg_addr == HTS_OFS_DATE);
    endsequence

    sequence s_read_month;
        reg_rd && (reg_addr == HTS_OFS_MONTH);
    endsequence

    chk_hours_read_value: assert property (
        s_read_hours |=> (reg_rdata_q == {2'h0, $past(hours_q)}))
        else $error("hours read does not show the stored hour");

    chk_hours_field_capture: assert property (
        s_last_event |=> (hours_q == $past(cal_hours[5:0])))
        else $error("hours field not taken from calendar bits 5:0");

    chk_upper_bits_zero: assert property (
        (reg_rd && (reg_addr == HTS_OFS_HOURS || reg_addr == HTS_OFS_DATE))
            |=> (reg_rdata_q[7:6] == 2'h0))
        else $error("hours or date upper bits not zero");

    chk_write_no_effect: assert property (
        (reg_wr && !capture && !hot_stamp_clear)
            |=> $stable(hours_q) && $stable(date_q) && $stable(month_q))
        else $error("host write altered a capture register");

    chk_first_kept: assert property (
        (stamp_held_q && hot_stamp_overwrite_select == HTS_KEEP_FIRST
            && !hot_stamp_clear) |=> $stable(hours_q) && stamp_held_q)
        else $error("keep-first stamp was overwritten");

    chk_clear_hours: assert property (
        (hot_stamp_clear && !capture) |=> (hot_event_hours == HTS_RESET_VAL))
        else $error("clear did not zero the hours register");

    chk_date_capture: assert property (
        s_first_event_empty |=> (date_q == $past(cal_date[5:0])) && stamp_held_q)
        else $error("date not captured on first event");

    chk_date_read_value: assert property (
        s_read_date |=> (reg_rdata_q == {2'h0, $past(date_q)}))
        else $error("date read does not show the stored date");

    chk_month_capture: assert property (
        s_last_event |=> (month_q == $past(cal_month[4:0])))
        else $error("month not captured on last event");

    chk_disabled_hold: assert property (
        (!hot_stamp_enable && !hot_stamp_clear)[*2]
            |-> $stable(hours_q) && $stable(month_q))
        else $error("recording while stamping disabled");

    chk_fields_together: assert property (
        capture |=> (hours_q == $past(cal_hours[5:0]))
            && (date_q == $past(cal_date[5:0]))
            && (month_q == $past(cal_month[4:0])))
        else $error("capture fields not loaded together");

    chk_clear_all: assert property (
        (hot_stamp_clear && !capture) |=> (date_q == 6'h00)
            && (month_q == 5'h00) && !stamp_held_q)
        else $error("clear did not zero date and month");

    chk_capture_wins: assert property (
        (capture && hot_stamp_clear) |=> stamp_held_q
            && (hours_q == $past(cal_hours[HTS_HOURS_W-1:0])))
        else $error("clear overrode a capture in the same cycle");

    chk_held_needs_capture: assert property (
        (!stamp_held_q && !capture) |=> !stamp_held_q)
        else $error("stamp held without a capture");

    chk_month_upper_zero: assert property (
        s_read_month |=> (reg_rdata_q[HTS_DATA_W-1:HTS_MONTH_W] == '0))
        else $error("month upper bits not zero");

    // Read data stand only in the cycle after a mapped read
    chk_rdata_idle: assert property (
        (!reg_rd || (reg_addr != HTS_OFS_HOURS && reg_addr != HTS_OFS_DATE
            && reg_addr != HTS_OFS_MONTH)) |=> (reg_rdata_q == HTS_UNMAPPED_VAL))
        else $error("read data not zero outside a register read");

    chk_date_last: assert property (
        s_last_event |=> (date_q == $past(cal_date[HTS_DATE_W-1:0])))
        else $error("date not captured on last event");

    chk_first_all_fields: assert property (
        s_first_event_empty |=> (hours_q == $past(cal_hours[HTS_HOURS_W-1:0]))
            && (month_q == $past(cal_month[HTS_MONTH_W-1:0])))
        else $error("first event did not fill hours and month");

endmodule

// File: tb/hts_cal_model.sv
// Calendar time base seen by the capture block, loaded by the bench
`timescale 1ns/1ps
module hts_cal_model (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Load request
    input wire logic set,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] hours_in,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] date_in,
    input wire logic [hts_pkg::HTS_DATA_W-1:0] month_in,
    // Calendar outputs (BCD)
    output logic [hts_pkg::HTS_DATA_W-1:0] cal_hours,
    output logic [hts_pkg::HTS_DATA_W-1:0] cal_date,
    output logic [hts_pkg::HTS_DATA_W-1:0] cal_month
);
    import hts_pkg::*;

    // ------------------------------------------------------------
    // Time registers
    // ------------------------------------------------------------
    // Calendar starts at hour 00 of the first day of the first month
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cal_hours <= 8'h00;
            cal_date <= 8'h01;
            cal_month <= 8'h01;
        end
        else if (set)
        begin
            cal_hours <= hours_in;
            cal_date <= date_in;
            cal_month <= month_in;
        end
    end
endmodule

// File: tb/tb.sv
// Self-checking bench for the over-temperature time-stamp block
`timescale 1ns/1ps
module tb;
    import hts_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [HTS_ADDR_W-1:0] reg_addr = 8'h00;
    logic [HTS_DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [HTS_DATA_W-1:0] reg_rdata_q;
    logic [HTS_DATA_W-1:0] cal_hours;
    logic [HTS_DATA_W-1:0] cal_date;
    logic [HTS_DATA_W-1:0] cal_month;
    logic [HTS_DATA_W-1:0] set_hours = 8'h00;
    logic [HTS_DATA_W-1:0] set_date = 8'h01;
    logic [HTS_DATA_W-1:0] set_month = 8'h01;
    logic cal_set = 1'b0;
    logic hot_event = 1'b0;
    logic hot_stamp_enable = 1'b0;
    logic hot_stamp_overwrite_select = HTS_KEEP_FIRST;
    logic hot_stamp_clear = 1'b0;
    logic stamp_held_q;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    always #50 clock = ~clock;

    hts_stamp u_hts_stamp (
        .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .cal_hours(cal_hours), .cal_date(cal_date), .cal_month(cal_month),
        .hot_event(hot_event), .hot_stamp_enable(hot_stamp_enable),
        .hot_stamp_overwrite_select(hot_stamp_overwrite_select),
        .hot_stamp_clear(hot_stamp_clear), .stamp_held_q(stamp_held_q)
    );

    hts_cal_model u_hts_cal_model (
        .clock(clock), .nrst(nrst), .set(cal_set), .hours_in(set_hours),
        .date_in(set_date), .month_in(set_month), .cal_hours(cal_hours),
        .cal_date(cal_date), .cal_month(cal_month)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // Read data are looked at only in the cycle after the strobe
    task automatic read_check(input string what, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check(what, exp, reg_rdata_q);
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic check_all(input logic [7:0] h, input logic [7:0] d, input logic [7:0] m);
        read_check("hours", HTS_OFS_HOURS, h);
        read_check("date", HTS_OFS_DATE, d);
        read_check("month", HTS_OFS_MONTH, m);
    endtask

    // Loads the calendar, then raises one event that sees the new time
    task automatic stamp(input logic [7:0] h, input logic [7:0] d, input logic [7:0] m);
        @(posedge clock);
        cal_set <= 1'b1;
        set_hours <= h;
        set_date <= d;
        set_month <= m;
        @(posedge clock);
        cal_set <= 1'b0;
        hot_event <= 1'b1;
        @(posedge clock);
        hot_event <= 1'b0;
    endtask

    task automatic pulse_clear;
        @(posedge clock);
        hot_stamp_clear <= 1'b1;
        @(posedge clock);
        hot_stamp_clear <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Timeout
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        check_all(8'h00, 8'h00, 8'h00);
        read_check("unmapped", 8'h25, HTS_UNMAPPED_VAL);
        stamp(8'h12, 8'h05, 8'h03);
        check_all(8'h00, 8'h00, 8'h00);
        check("held", 8'h00, {7'h00, stamp_held_q});
        @(posedge clock);
        hot_stamp_enable <= 1'b1;
        stamp(8'h23, 8'h31, 8'h12);
        check_all(8'h23, 8'h31, 8'h12);
        check("held", 8'h01, {7'h00, stamp_held_q});
        stamp(8'h05, 8'h17, 8'h06);
        check_all(8'h23, 8'h31, 8'h12);
        write_reg(HTS_OFS_HOURS, 8'hff);
        write_reg(HTS_OFS_DATE, 8'hff);
        write_reg(HTS_OFS_MONTH, 8'hff);
        check_all(8'h23, 8'h31, 8'h12);
        @(posedge clock);
        hot_stamp_overwrite_select <= HTS_KEEP_LAST;
        stamp(8'h05, 8'h17, 8'h06);
        check_all(8'h05, 8'h17, 8'h06);
        @(posedge clock);
        hot_stamp_enable <= 1'b0;
        stamp(8'h11, 8'h11, 8'h11);
        check_all(8'h05, 8'h17, 8'h06);
        @(posedge clock);
        hot_stamp_enable <= 1'b1;
        pulse_clear();
        check_all(8'h00, 8'h00, 8'h00);
        check("held", 8'h00, {7'h00, stamp_held_q});
        // Upper calendar bits must never reach the stored fields
        stamp(8'hd9, 8'hc1, 8'he9);
        check_all(8'h19, 8'h01, 8'h09);
        // Event and clear in one cycle: the capture wins
        @(posedge clock);
        hot_stamp_clear <= 1'b1;
        hot_event <= 1'b1;
        @(posedge clock);
        hot_stamp_clear <= 1'b0;
        hot_event <= 1'b0;
        check_all(8'h19, 8'h01, 8'h09);
        check("held", 8'h01, {7'h00, stamp_held_q});
        wrap_up();
    end
endmodule
